/* File: core/cpu_ctl_regs.sv */
// instruction pointer, extended control and condition code registers
`default_nettype none
module cpu_ctl_regs
  import cpu_ctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic vec_load_i,
  input wire logic [23:0] vec_addr_i,
  input wire logic pc_load_i,
  input wire logic [23:0] pc_target_i,
  input wire logic pc_adv_i,
  output logic [23:0] next_instr_pointer_o,
  output logic [23:0] fetch_addr_o,
  input wire ctl_op_t ctl_op_i,
  input wire logic ctl_sel_ext_i,
  input wire logic [7:0] ctl_data_i,
  output logic [7:0] ctl_rdata_o,
  output logic ctl_rvalid_o,
  input wire logic alu_upd_i,
  input wire alu_kind_t alu_kind_i,
  input wire op_size_t alu_size_i,
  input wire logic [31:0] alu_a_i,
  input wire logic [31:0] alu_b_i,
  input wire logic alu_ext_c_i,
  output logic [31:0] alu_result_o,
  input wire logic [3:0] br_cond_i,
  output logic br_taken_o,
  input wire logic irq_i,
  input wire logic nmi_i,
  output logic irq_take_o,
  input wire logic exc_start_i,
  output logic [7:0] extended_control_o,
  output logic [7:0] condition_code_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PC_W-1:0] pc_r;
  logic trace_r;
  logic [2:0] lvl_r;
  logic imask_r;
  logic [6:0] flags_r;
  logic [6:0] flags_nxt;
  logic [7:0] xc_rd;
  logic [7:0] ccr_rd;
  logic [7:0] ccr_op;
  logic [7:0] xc_op;
  logic [7:0] upd_m;
  logic ctl_ccr;
  logic ctl_xc;
  logic [31:0] f_res;
  logic f_h;
  logic f_n;
  logic f_z;
  logic f_v;
  logic f_c;

  // which condition code bits an operation kind rewrites
  function automatic logic [7:0] upd_mask(alu_kind_t k);
    case (k)
      k_add, k_addx, k_sub, k_subx, k_cmp, k_neg: upd_mask = 8'h2f;
      k_logic: upd_mask = 8'h0e;
      k_shift: upd_mask = 8'h0f;
      k_bit: upd_mask = 8'h01;
      default: upd_mask = 8'h00;
    endcase
  endfunction : upd_mask

  // apply a write-type control op to a register image
  function automatic logic [7:0] ctl_apply(ctl_op_t op, logic [7:0] cur,
                                           logic [7:0] d);
    case (op)
      load_control_op: ctl_apply = d;
      and_control_op: ctl_apply = cur & d;
      or_control_op: ctl_apply = cur | d;
      xor_control_op: ctl_apply = cur ^ d;
      default: ctl_apply = cur;
    endcase
  endfunction : ctl_apply

  function automatic logic br_eval(logic [3:0] cc, logic n, logic z,
                                   logic v, logic c);
    case (cc)
      BR_T: br_eval = 1'b1;
      BR_F: br_eval = 1'b0;
      BR_HI: br_eval = !(c | z);
      BR_LS: br_eval = c | z;
      BR_CC: br_eval = !c;
      BR_CS: br_eval = c;
      BR_NE: br_eval = !z;
      BR_EQ: br_eval = z;
      BR_VC: br_eval = !v;
      BR_VS: br_eval = v;
      BR_PL: br_eval = !n;
      BR_MI: br_eval = n;
      BR_GE: br_eval = !(n ^ v);
      BR_LT: br_eval = n ^ v;
      BR_GT: br_eval = !(z | (n ^ v));
      default: br_eval = z | (n ^ v);
    endcase
  endfunction : br_eval

  // ----------------------------------------------------------------
  // instruction pointer
  // ----------------------------------------------------------------
  // vector load beats a jump, a jump beats the plain advance
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_r <= PC_RST;
    end else if (vec_load_i) begin
      pc_r <= vec_addr_i;
    end else if (pc_load_i) begin
      pc_r <= pc_target_i;
    end else if (pc_adv_i) begin
      pc_r <= pc_r + INSTR_BYTES;
    end
  end

  assign next_instr_pointer_o = pc_r;
  // odd targets fetch from the preceding even address
  assign fetch_addr_o = {pc_r[PC_W-1:1], 1'b0};

  // ----------------------------------------------------------------
  // control op decode
  // ----------------------------------------------------------------
  assign ctl_ccr = !ctl_sel_ext_i && (ctl_op_i != no_control_op) &&
                   (ctl_op_i != store_control_op);
  assign ctl_xc = ctl_sel_ext_i && (ctl_op_i != no_control_op) &&
                  (ctl_op_i != store_control_op);
  assign ccr_op = ctl_apply(ctl_op_i, ccr_rd, ctl_data_i);
  assign xc_op = ctl_apply(ctl_op_i, xc_rd, ctl_data_i);

  // ----------------------------------------------------------------
  // extended control
  // ----------------------------------------------------------------
  // trace and level are stored only; they feed only extended_control_o, the read-back and the control op paths
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trace_r <= XC_TRACE_RST;
      lvl_r <= XC_LVL_RST;
    end else if (ctl_xc) begin
      trace_r <= xc_op[XC_TRACE];
      lvl_r <= xc_op[2:0];
    end
  end

  assign xc_rd = {trace_r, XC_RSV_VAL, lvl_r};
  assign extended_control_o = xc_rd;

  // ----------------------------------------------------------------
  // condition code
  // ----------------------------------------------------------------
  cc_flag_calc u_flags (
    .kind_i(alu_kind_i),
    .size_i(alu_size_i),
    .a_i(alu_a_i),
    .b_i(alu_b_i),
    .c_old_i(flags_r[CC_C]),
    .ext_c_i(alu_ext_c_i),
    .res_o(f_res),
    .h_o(f_h),
    .n_o(f_n),
    .z_o(f_z),
    .v_o(f_v),
    .c_o(f_c)
  );

  // exception entry forces the mask and wins over a same-cycle write
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      imask_r <= CC_I_RST;
    end else if (exc_start_i) begin
      imask_r <= 1'b1;
    end else if (ctl_ccr) begin
      imask_r <= ccr_op[CC_I];
    end
  end

  assign upd_m = upd_mask(alu_kind_i);

  // a control op in the same cycle as a flag update takes priority
  always_comb begin
    flags_nxt = flags_r;
    if (ctl_ccr) begin
      flags_nxt = ccr_op[6:0];
    end else if (alu_upd_i) begin
      flags_nxt = (flags_r & ~upd_m[6:0]) |
                  ({1'b0, f_h, 1'b0, f_n, f_z, f_v, f_c} & upd_m[6:0]);
    end
  end

  // user bits and flags are left uninitialised by reset
  always_ff @(posedge mclk_i) begin
    flags_r <= flags_nxt;
  end

  assign ccr_rd = {imask_r, flags_r};
  assign condition_code_o = ccr_rd;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alu_result_o <= 32'h00000000;
    end else if (alu_upd_i) begin
      alu_result_o <= f_res;
    end
  end

  // ----------------------------------------------------------------
  // store path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_rdata_o <= 8'h00;
      ctl_rvalid_o <= 1'b0;
    end else begin
      ctl_rvalid_o <= (ctl_op_i == store_control_op);
      if (ctl_op_i == store_control_op) begin
        ctl_rdata_o <= ctl_sel_ext_i ? xc_rd : ccr_rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // branch and interrupt gating
  // ----------------------------------------------------------------
  assign br_taken_o = br_eval(br_cond_i, flags_r[CC_N], flags_r[CC_Z],
                              flags_r[CC_V], flags_r[CC_C]);
  assign irq_take_o = nmi_i || (irq_i && !imask_r);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_plain_adv;
    pc_adv_i && !pc_load_i && !vec_load_i;
  endsequence

  sequence s_ccr_xor;
    ctl_op_i == xor_control_op && !ctl_sel_ext_i && !exc_start_i;
  endsequence

  sequence s_xc_load;
    ctl_op_i == load_control_op && ctl_sel_ext_i;
  endsequence

  sequence s_arith_upd;
    alu_upd_i && !ctl_ccr && upd_mask(alu_kind_i) == 8'h2f;
  endsequence

  sequence s_byte_add;
    s_arith_upd ##0 alu_kind_i == k_add && alu_size_i == sz_byte;
  endsequence

  a_pc_advance: assert property (
    s_plain_adv |=> pc_r == $past(pc_r) + INSTR_BYTES)
    else $error("pointer did not advance by one instruction");

  a_fetch_even: assert property (
    pc_load_i && !vec_load_i |=> !fetch_addr_o[0] &&
      fetch_addr_o[PC_W-1:1] == $past(pc_target_i[PC_W-1:1]))
    else $error("fetch address not the even form of the target");

  a_trace_load: assert property (
    s_xc_load |=> extended_control_o[XC_TRACE] ==
      $past(ctl_data_i[XC_TRACE]))
    else $error("trace bit not loaded");

  a_xc_reserved: assert property (
    s_xc_load |=> extended_control_o[6:3] == XC_RSV_VAL)
    else $error("reserved extended control bits not read as ones");

  a_level_load: assert property (
    s_xc_load |=> extended_control_o[2:0] == $past(ctl_data_i[2:0]))
    else $error("mask level not loaded");

  a_ccr_xor: assert property (
    s_ccr_xor |=> condition_code_o == ($past(ccr_rd) ^ $past(ctl_data_i)))
    else $error("condition code xor wrong");

  a_store_read: assert property (
    ctl_op_i == store_control_op |=> ctl_rvalid_o &&
      ctl_rdata_o == $past(ctl_sel_ext_i ? xc_rd : ccr_rd))
    else $error("stored value does not match register");

  a_branch_eq: assert property (
    br_cond_i == BR_EQ |-> br_taken_o == condition_code_o[CC_Z])
    else $error("equal branch not decided by zero flag");

  a_irq_masked: assert property (
    irq_i && !nmi_i && condition_code_o[CC_I] |-> !irq_take_o)
    else $error("masked interrupt accepted");

  a_nmi_taken: assert property (
    nmi_i |-> irq_take_o)
    else $error("non-maskable interrupt refused");

  a_exc_mask: assert property (
    exc_start_i |=> condition_code_o[CC_I] ##1
      (condition_code_o[CC_I] || $past(ctl_ccr)))
    else $error("mask bit not set on exception entry");

  a_half_byte: assert property (
    s_byte_add |=> condition_code_o[CC_H] ==
      $past(({1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]}) > 5'h0f))
    else $error("byte half carry wrong");

  a_carry_byte: assert property (
    s_byte_add |=> condition_code_o[CC_C] ==
      $past(({1'b0, alu_a_i[7:0]} + {1'b0, alu_b_i[7:0]}) > 9'h0ff))
    else $error("byte carry wrong");

  a_zero_flag: assert property (
    s_arith_upd |=> condition_code_o[CC_Z] ==
      ($past(f_res) == 32'h00000000) && alu_result_o == $past(f_res))
    else $error("zero flag disagrees with result");

  a_neg_flag: assert property (
    s_arith_upd ##0 alu_size_i == sz_word |=>
      condition_code_o[CC_N] == alu_result_o[15])
    else $error("negative flag not the sign bit");

endmodule : cpu_ctl_regs
`default_nettype wire

/* File: core/cpu_ctl_pkg.sv */
// package: processor control register layout, op codes and flag helpers
`default_nettype none
// Function
// - keep a 24-bit pointer to the next instruction to execute
// - instruction fetch address always has its lowest bit forced to zero
// - trace bit 7 of extended control resets to 0, read/write, no effect
// - extended control bits 6 to 3 always read as ones
// - extended control bits 2 to 0: mask level, reset 1s, no effect
// - condition code is 8 bits: mask, two user bits, H N Z V C
// - control ops load, store, and, or, xor act on condition code bits
// - conditional branches are decided from N, Z, V and C
// - mask bit 7 resets to 1 and blocks all but non-maskable interrupts
// - non-maskable interrupt is always accepted
// - mask bit is set at the start of every exception sequence
// - bits 6 and 4 are user bits, undefined at reset, freely written
// - byte add/addx/sub/subx/cmp/neg: H is carry or borrow at bit 3
// - word add/sub/cmp/neg: H is carry or borrow at bit 11
// - long add/sub/cmp/neg: H is carry or borrow at bit 27
// - N takes the most significant bit of the result
// - Z is 1 for a zero result and 0 otherwise
// - V is 1 on arithmetic overflow and 0 otherwise
// - C: add carry, subtract borrow, shift carry; bit accumulator
// - reset loads pointer with 0, clears trace, sets both masks
package cpu_ctl_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int PC_W = 24;
  localparam logic [23:0] INSTR_BYTES = 24'h000002;
  localparam logic [23:0] PC_RST = 24'h000000;
  localparam logic XC_TRACE_RST = 1'b0;
  localparam logic [2:0] XC_LVL_RST = 3'h7;
  localparam logic [3:0] XC_RSV_VAL = 4'hf;
  localparam logic CC_I_RST = 1'b1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int XC_TRACE = 7;
  localparam int CC_I = 7, CC_U6 = 6, CC_H = 5, CC_U = 4;
  localparam int CC_N = 3, CC_Z = 2, CC_V = 1, CC_C = 0;
  localparam int HB_BYTE = 3, HB_WORD = 11, HB_LONG = 27;

  // ----------------------------------------------------------------
  // branch condition codes
  // ----------------------------------------------------------------
  localparam logic [3:0] BR_T = 4'h0, BR_F = 4'h1, BR_HI = 4'h2;
  localparam logic [3:0] BR_LS = 4'h3, BR_CC = 4'h4, BR_CS = 4'h5;
  localparam logic [3:0] BR_NE = 4'h6, BR_EQ = 4'h7, BR_VC = 4'h8;
  localparam logic [3:0] BR_VS = 4'h9, BR_PL = 4'ha, BR_MI = 4'hb;
  localparam logic [3:0] BR_GE = 4'hc, BR_LT = 4'hd, BR_GT = 4'he;
  localparam logic [3:0] BR_LE = 4'hf;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    no_control_op    = 6'h01,
    load_control_op  = 6'h02,
    store_control_op = 6'h04,
    and_control_op   = 6'h08,
    or_control_op    = 6'h10,
    xor_control_op   = 6'h20
  } ctl_op_t;

  typedef enum logic [2:0] {
    sz_byte = 3'h1,
    sz_word = 3'h2,
    sz_long = 3'h4
  } op_size_t;

  typedef enum logic [8:0] {
    k_add   = 9'h001,
    k_addx  = 9'h002,
    k_sub   = 9'h004,
    k_subx  = 9'h008,
    k_cmp   = 9'h010,
    k_neg   = 9'h020,
    k_logic = 9'h040,
    k_shift = 9'h080,
    k_bit   = 9'h100
  } alu_kind_t;

  function automatic int size_msb(op_size_t s);
    case (s)
      sz_byte: size_msb = 7;
      sz_word: size_msb = 15;
      default: size_msb = 31;
    endcase
  endfunction : size_msb

  function automatic int half_bit(op_size_t s);
    case (s)
      sz_byte: half_bit = HB_BYTE;
      sz_word: half_bit = HB_WORD;
      default: half_bit = HB_LONG;
    endcase
  endfunction : half_bit

  function automatic logic [31:0] size_mask(op_size_t s);
    case (s)
      sz_byte: size_mask = 32'h000000ff;
      sz_word: size_mask = 32'h0000ffff;
      default: size_mask = 32'hffffffff;
    endcase
  endfunction : size_mask

endpackage : cpu_ctl_pkg
`default_nettype wire

/* File: core/cc_flag_calc.sv */
// flag calculation for one arithmetic, logic, shift or bit operation
`default_nettype none
module cc_flag_calc
  import cpu_ctl_pkg::*;
(
  input wire alu_kind_t kind_i,
  input wire op_size_t size_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic c_old_i,
  input wire logic ext_c_i,
  output logic [31:0] res_o,
  output logic h_o,
  output logic n_o,
  output logic z_o,
  output logic v_o,
  output logic c_o
);

  logic [32:0] ext;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] hx;
  logic cin;
  logic is_sub;
  int msb;
  int hb;

  always_comb begin
    msb = size_msb(size_i);
    hb = half_bit(size_i);
    opa = a_i & size_mask(size_i);
    opb = b_i & size_mask(size_i);
    // negate is 0 - a, so the operand moves to the subtrahend
    if (kind_i == k_neg) begin
      opb = opa;
      opa = 32'h00000000;
    end
    cin = c_old_i & ((kind_i == k_addx) || (kind_i == k_subx));
    is_sub = (kind_i == k_sub) || (kind_i == k_subx) ||
             (kind_i == k_cmp) || (kind_i == k_neg);
    if (kind_i == k_add || kind_i == k_addx) begin
      ext = {1'b0, opa} + {1'b0, opb} + {32'h00000000, cin};
    end else if (is_sub) begin
      ext = {1'b0, opa} - {1'b0, opb} - {32'h00000000, cin};
    end else begin
      ext = {1'b0, opa};
    end
    res_o = ext[31:0] & size_mask(size_i);
    // bit k+1 of a^b^r is the carry or borrow into it
    hx = ext[31:0] ^ opa ^ opb;
    h_o = hx[hb + 1];
    n_o = res_o[msb];
    z_o = (res_o == 32'h00000000);
    if (is_sub) begin
      v_o = (opa[msb] != opb[msb]) && (res_o[msb] != opa[msb]);
      c_o = ext[msb + 1];
    end else if (kind_i == k_add || kind_i == k_addx) begin
      v_o = (opa[msb] == opb[msb]) && (res_o[msb] != opa[msb]);
      c_o = ext[msb + 1];
    end else if (kind_i == k_shift || kind_i == k_bit) begin
      v_o = 1'b0;
      c_o = ext_c_i;
    end else begin
      v_o = 1'b0;
      c_o = c_old_i;
    end
  end

endmodule : cc_flag_calc
`default_nettype wire

/* File: tb/test_cpu_ctl_regs.sv */
// self-checking bench for the processor control registers
`default_nettype none
module test_cpu_ctl_regs
  import cpu_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk_i, rstn_i, vec_load_i, pc_load_i, pc_adv_i;
  logic [23:0] vec_addr_i, pc_target_i, next_instr_pointer_o, fetch_addr_o;
  ctl_op_t ctl_op_i;
  logic ctl_sel_ext_i, ctl_rvalid_o, alu_upd_i, alu_ext_c_i;
  logic [7:0] ctl_data_i, ctl_rdata_o, extended_control_o, condition_code_o;
  alu_kind_t alu_kind_i;
  op_size_t alu_size_i;
  logic [31:0] alu_a_i, alu_b_i, alu_result_o;
  logic [3:0] br_cond_i;
  logic br_taken_o, irq_i, nmi_i, irq_take_o, exc_start_i;
  logic rv_seen;
  logic [7:0] rd_seen, exp_cc;
  int error_cnt, checked;

  cpu_ctl_regs cpu_ctl_regs_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .vec_load_i(vec_load_i),
    .vec_addr_i(vec_addr_i), .pc_load_i(pc_load_i),
    .pc_target_i(pc_target_i), .pc_adv_i(pc_adv_i),
    .next_instr_pointer_o(next_instr_pointer_o),
    .fetch_addr_o(fetch_addr_o), .ctl_op_i(ctl_op_i),
    .ctl_sel_ext_i(ctl_sel_ext_i), .ctl_data_i(ctl_data_i),
    .ctl_rdata_o(ctl_rdata_o), .ctl_rvalid_o(ctl_rvalid_o),
    .alu_upd_i(alu_upd_i), .alu_kind_i(alu_kind_i),
    .alu_size_i(alu_size_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
    .alu_ext_c_i(alu_ext_c_i), .alu_result_o(alu_result_o),
    .br_cond_i(br_cond_i), .br_taken_o(br_taken_o), .irq_i(irq_i),
    .nmi_i(nmi_i), .irq_take_o(irq_take_o), .exc_start_i(exc_start_i),
    .extended_control_o(extended_control_o),
    .condition_code_o(condition_code_o)
  );

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // every task starts and ends just after a falling edge
  task pc(input logic v, l, a, input logic [23:0] va, ta);
    vec_load_i = v;
    pc_load_i = l;
    pc_adv_i = a;
    vec_addr_i = va;
    pc_target_i = ta;
    @(negedge mclk_i);
    {vec_load_i, pc_load_i, pc_adv_i} = 3'h0;
    @(negedge mclk_i);
  endtask : pc

  task ctl(input ctl_op_t op, input logic sel, input logic [7:0] d);
    ctl_op_i = op;
    ctl_sel_ext_i = sel;
    ctl_data_i = d;
    @(negedge mclk_i);
    rv_seen = ctl_rvalid_o;
    rd_seen = ctl_rdata_o;
    ctl_op_i = no_control_op;
    @(negedge mclk_i);
  endtask : ctl

  // exception start, optionally racing a condition code load
  task exc(input logic wr, input logic [7:0] d);
    exc_start_i = 1'b1;
    ctl_op_i = wr ? load_control_op : no_control_op;
    ctl_sel_ext_i = 1'b0;
    ctl_data_i = d;
    @(negedge mclk_i);
    exc_start_i = 1'b0;
    ctl_op_i = no_control_op;
    @(negedge mclk_i);
  endtask : exc

  // val/mask: flags this kind writes; dc: bits whose value is not known
  task alu(input alu_kind_t k, input op_size_t s, input logic [31:0] a, b,
           input logic e, input logic [31:0] res, input logic rchk,
           input logic [7:0] val, mask, dc);
    alu_kind_i = k;
    alu_size_i = s;
    alu_a_i = a;
    alu_b_i = b;
    alu_ext_c_i = e;
    alu_upd_i = 1'b1;
    @(negedge mclk_i);
    alu_upd_i = 1'b0;
    @(negedge mclk_i);
    exp_cc = (exp_cc & ~mask) | (val & mask);
    check(condition_code_o & ~dc, exp_cc & ~dc);
    if (rchk) begin
      check(alu_result_o, res);
    end
  endtask : alu

  task br(input logic [7:0] ccv, input logic [15:0] expv);
    ctl(load_control_op, 1'b0, ccv);
    for (int i = 0; i < 16; i++) begin
      br_cond_i = i[3:0];
      @(negedge mclk_i);
      check(br_taken_o, expv[i]);
    end
  endtask : br

  // ----------------------------------------------------------------
  // watchdog: the tests need about 165 cycles
  // ----------------------------------------------------------------
  initial begin
    #(2000 * 25);
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checked = 0;
    exp_cc = 8'h00;
    rstn_i = 1'b0;
    {vec_load_i, pc_load_i, pc_adv_i, alu_upd_i, alu_ext_c_i} = 5'h00;
    {irq_i, nmi_i, exc_start_i, ctl_sel_ext_i} = 4'h0;
    vec_addr_i = 24'h000000;
    pc_target_i = 24'h000000;
    ctl_op_i = no_control_op;
    ctl_data_i = 8'h00;
    alu_kind_i = k_add;
    alu_size_i = sz_byte;
    alu_a_i = 32'h00000000;
    alu_b_i = 32'h00000000;
    br_cond_i = 4'h0;
    repeat (8) @(negedge mclk_i);
    check(next_instr_pointer_o, 24'h000000);
    check(extended_control_o, 8'h7f);
    check(condition_code_o[7], 1'b1);
    check(ctl_rvalid_o, 1'b0);
    rstn_i = 1'b1;
    @(negedge mclk_i);
    // pointer: vector load, advance, priorities, wrap
    pc(1'b1, 1'b0, 1'b0, 24'h123457, 24'h000000);
    check(next_instr_pointer_o, 24'h123457);
    check(fetch_addr_o, 24'h123456);
    pc(1'b0, 1'b0, 1'b1, 24'h000000, 24'h000000);
    check(next_instr_pointer_o, 24'h123459);
    check(fetch_addr_o, 24'h123458);
    pc(1'b0, 1'b1, 1'b1, 24'h000000, 24'habcdef);
    check(next_instr_pointer_o, 24'habcdef);
    pc(1'b1, 1'b1, 1'b1, 24'h000100, 24'habcdef);
    check(next_instr_pointer_o, 24'h000100);
    pc(1'b0, 1'b1, 1'b0, 24'h000000, 24'hffffff);
    pc(1'b0, 1'b0, 1'b1, 24'h000000, 24'h000000);
    check(next_instr_pointer_o, 24'h000001);
    check(fetch_addr_o, 24'h000000);
    // extended control: reserved bits stay high whatever is written
    ctl(load_control_op, 1'b1, 8'h00);
    check(extended_control_o, 8'h78);
    ctl(xor_control_op, 1'b1, 8'h85);
    check(extended_control_o, 8'hfd);
    ctl(and_control_op, 1'b1, 8'h07);
    check(extended_control_o, 8'h7d);
    ctl(or_control_op, 1'b1, 8'h80);
    ctl(store_control_op, 1'b1, 8'h00);
    check(rv_seen, 1'b1);
    check(rd_seen, 8'hfd);
    check(ctl_rvalid_o, 1'b0);
    // condition code control ops, user bits included
    ctl(load_control_op, 1'b0, 8'h00);
    check(condition_code_o, 8'h00);
    ctl(or_control_op, 1'b0, 8'h50);
    check(condition_code_o, 8'h50);
    ctl(and_control_op, 1'b0, 8'h10);
    ctl(xor_control_op, 1'b0, 8'h41);
    ctl(store_control_op, 1'b0, 8'h00);
    check(rd_seen, 8'h51);
    // interrupt gating and exception start
    ctl(load_control_op, 1'b0, 8'h00);
    irq_i = 1'b1;
    @(negedge mclk_i);
    check(irq_take_o, 1'b1);
    ctl(or_control_op, 1'b0, 8'h80);
    check(irq_take_o, 1'b0);
    nmi_i = 1'b1;
    @(negedge mclk_i);
    check(irq_take_o, 1'b1);
    {irq_i, nmi_i} = 2'h0;
    ctl(load_control_op, 1'b0, 8'h00);
    exc(1'b0, 8'h00);
    check(condition_code_o, 8'h80);
    ctl(load_control_op, 1'b0, 8'h00);
    exc(1'b1, 8'h35);
    check(condition_code_o, 8'hb5);
    // branch conditions for several flag patterns
    br(8'h00, 16'h5555);
    br(8'h0f, 16'h9aa9);
    br(8'h08, 16'ha955);
    br(8'h02, 16'ha655);
    // flag updates
    ctl(load_control_op, 1'b0, 8'h00);
    alu(k_add, sz_byte, 32'h0f, 32'h01, 1'b0, 32'h10, 1'b1, 8'h20, 8'h2f,
        8'h00);
    alu(k_add, sz_byte, 32'h7f, 32'h01, 1'b0, 32'h80, 1'b1, 8'h2a, 8'h2f,
        8'h00);
    alu(k_add, sz_byte, 32'hff, 32'h01, 1'b0, 32'h00, 1'b1, 8'h25, 8'h2f,
        8'h00);
    alu(k_sub, sz_byte, 32'h10, 32'h01, 1'b0, 32'h0f, 1'b1, 8'h20, 8'h2f,
        8'h00);
    alu(k_cmp, sz_byte, 32'h00, 32'h01, 1'b0, 32'h0, 1'b0, 8'h29, 8'h2f,
        8'h00);
    alu(k_neg, sz_byte, 32'h01, 32'h00, 1'b0, 32'hff, 1'b1, 8'h29, 8'h2f,
        8'h00);
    alu(k_add, sz_word, 32'h0fff, 32'h1, 1'b0, 32'h1000, 1'b1, 8'h20, 8'h2f,
        8'h00);
    alu(k_add, sz_word, 32'h8000, 32'h8000, 1'b0, 32'h0, 1'b1, 8'h07, 8'h2f,
        8'h00);
    alu(k_sub, sz_word, 32'h1000, 32'h1, 1'b0, 32'h0fff, 1'b1, 8'h20, 8'h2f,
        8'h00);
    alu(k_neg, sz_word, 32'h0001, 32'h0, 1'b0, 32'hffff, 1'b1, 8'h29, 8'h2f,
        8'h00);
    alu(k_add, sz_long, 32'h0fffffff, 32'h1, 1'b0, 32'h10000000, 1'b1, 8'h20,
        8'h2f, 8'h00);
    alu(k_cmp, sz_long, 32'h0, 32'h1, 1'b0, 32'h0, 1'b0, 8'h29, 8'h2f,
        8'h00);
    alu(k_sub, sz_long, 32'h0, 32'h1, 1'b0, 32'hffffffff, 1'b1, 8'h29, 8'h2f,
        8'h00);
    // logic leaves H and C alone, so the carry from above must survive
    alu(k_logic, sz_byte, 32'h0, 32'h0, 1'b0, 32'h0, 1'b1, 8'h04, 8'h0e,
        8'h00);
    alu(k_addx, sz_byte, 32'h0f, 32'h00, 1'b0, 32'h10, 1'b1, 8'h20, 8'h2f,
        8'h00);
    alu(k_subx, sz_byte, 32'h05, 32'h05, 1'b0, 32'h00, 1'b1, 8'h04, 8'h2f,
        8'h00);
    alu(k_shift, sz_byte, 32'h0, 32'h0, 1'b1, 32'h0, 1'b0, 8'h01, 8'h0f,
        8'h0c);
    alu(k_bit, sz_byte, 32'h0, 32'h0, 1'b0, 32'h0, 1'b0, 8'h00, 8'h01,
        8'h0c);
    summarize();
  end

endmodule : test_cpu_ctl_regs
`default_nettype wire
